// ==== design/earom_pkg.sv ====
/*
 Constants, types and shared decoding for the serial word memory sequencer.
 Assumes a 100 MHz system clock and a 32-bit AXI4-Lite register bus.
*/
package earom_pkg;
   localparam int WORDS     = 100;
   localparam int WORD_W    = 14;
   localparam int GRP_N     = 10;
   localparam int ADDR_W    = 2 * GRP_N;
   localparam int IDX_W     = 7;
   localparam int CNT_W     = 24;
   localparam int NSYNC     = 5;
   localparam int NFLAGS    = 3;
   localparam int AXI_AW    = 8;

   localparam logic [IDX_W-1:0] GRP_SCALE = 7'h0A;

   localparam int CLK_HZ                 = 100_000_000;
   localparam int PROGRAM_DURATION_MIN_MS = 16;
   localparam int CLEAR_DURATION_MIN_MS   = 16;
   localparam int PROGRAM_CYC = PROGRAM_DURATION_MIN_MS * (CLK_HZ / 1000);
   localparam int CLEAR_CYC   = CLEAR_DURATION_MIN_MS * (CLK_HZ / 1000);

   localparam logic [AXI_AW-1:0] REG_CTRL   = 8'h00;
   localparam logic [AXI_AW-1:0] REG_STATUS = 8'h04;
   localparam logic [AXI_AW-1:0] REG_FLAGS  = 8'h08;
   localparam logic [AXI_AW-1:0] REG_ADDR   = 8'h0C;
   localparam logic [AXI_AW-1:0] REG_DATA   = 8'h10;

   localparam int CTRL_PROTECT_BIT = 0;
   localparam int FLAG_DONE        = 0;
   localparam int FLAG_ABORT       = 1;
   localparam int FLAG_REFUSED     = 2;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_DECERR = 2'h3;

   typedef enum logic [2:0] {
      MD_STANDBY   = 3'h0,
      MD_UNUSED    = 3'h1,
      MD_ERASE     = 3'h2,
      MD_ACC_ADDR  = 3'h3,
      MD_READ      = 3'h4,
      MD_SHIFT_OUT = 3'h5,
      MD_WRITE     = 3'h6,
      MD_ACC_DATA  = 3'h7
   } mode_t;

   typedef enum logic [1:0] {
      OP_IDLE  = 2'h0,
      OP_DWELL = 2'h1,
      OP_DONE  = 2'h2
   } op_state_t;

   // Returns {valid, position}; valid only when exactly one bit is set.
   function automatic logic [4:0] onehot_idx(input logic [GRP_N-1:0] g);
      logic [3:0] pos;
      logic [3:0] ones;
      pos  = 4'h0;
      ones = 4'h0;
      for (int i = 0; i < GRP_N; i++) begin
         if (g[i]) begin
            pos  = 4'(i);
            ones = ones + 4'h1;
         end
      end
      return {(ones == 4'h1), pos};
   endfunction : onehot_idx
endpackage : earom_pkg

// ==== design/reg_if.sv ====
/*
 Carrier between the register slave and the sequencer core.
 Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
interface reg_if;
   import earom_pkg::*;
   logic              protect;
   logic [NFLAGS-1:0] flag_set;
   logic [31:0]       status;
   logic [31:0]       addr_view;
   logic [31:0]       data_view;
   modport regs (output protect, input flag_set, status, addr_view, data_view);
   modport core (input protect, output flag_set, status, addr_view, data_view);
endinterface : reg_if

// ==== design/earom_array.sv ====
/*
 Word store of the serial memory, one whole word per access.
 Assumes the caller gives an index below the word count when writing.
*/
`timescale 1ns/1ps
module earom_array
   import earom_pkg::*;
#(
   parameter int N_WORDS = WORDS,
   parameter int W       = WORD_W
) (
   input  wire logic             ref_clk,
   input  wire logic [IDX_W-1:0] rd_idx,
   output logic      [W-1:0]     rd_data,
   input  wire logic             wr_en,
   input  wire logic [IDX_W-1:0] wr_idx,
   input  wire logic [W-1:0]     wr_data
);
   if (N_WORDS > (1 << IDX_W)) begin : g_bad_depth
      $error("earom_array: word count exceeds index width");
   end

   logic [W-1:0] mem [N_WORDS];

   // Contents have no reset: like the real cells they keep whatever was stored.
   assign rd_data = (32'(rd_idx) < N_WORDS) ? mem[rd_idx] : '0;

   always_ff @(posedge ref_clk) begin
      if (wr_en && (32'(wr_idx) < N_WORDS)) begin
         mem[wr_idx] <= wr_data;
      end
   end
endmodule : earom_array

// ==== design/earom_axil_regs.sv ====
/*
 AXI4-Lite register slave: control, status, sticky flags, register views.
 Assumes a master that keeps to one outstanding write and one outstanding read.
*/
`timescale 1ns/1ps
module earom_axil_regs
   import earom_pkg::*;
(
   input  wire logic              ref_clk,
   input  wire logic              rst_n,
   input  wire logic [AXI_AW-1:0] awaddr,
   input  wire logic              awvalid,
   output logic                   awready,
   input  wire logic [31:0]       wdata,
   input  wire logic [3:0]        wstrb,
   input  wire logic              wvalid,
   output logic                   wready,
   output logic [1:0]             bresp,
   output logic                   bvalid,
   input  wire logic              bready,
   input  wire logic [AXI_AW-1:0] araddr,
   input  wire logic              arvalid,
   output logic                   arready,
   output logic [31:0]            rdata,
   output logic [1:0]             rresp,
   output logic                   rvalid,
   input  wire logic              rready,
   reg_if.regs                    rb
);
   function automatic logic mapped(input logic [AXI_AW-1:0] a);
      return (a == REG_CTRL) || (a == REG_STATUS) || (a == REG_FLAGS) ||
             (a == REG_ADDR) || (a == REG_DATA);
   endfunction : mapped

   logic [AXI_AW-1:0] awaddr_q;
   logic [31:0]       wdata_q;
   logic [3:0]        wstrb_q;
   logic              aw_full_q, w_full_q, protect_q;
   logic [NFLAGS-1:0] flags_q;

   wire               aw_take = awvalid && awready;
   wire               w_take  = wvalid && wready;
   wire               commit  = aw_full_q && w_full_q && !bvalid;
   wire               lane0   = commit && wstrb_q[0];
   wire [NFLAGS-1:0]  clr     = (lane0 && awaddr_q == REG_FLAGS) ? wdata_q[NFLAGS-1:0] : '0;
   wire               aw_full_d = !commit && (aw_full_q || aw_take);
   wire               w_full_d  = !commit && (w_full_q || w_take);
   wire [31:0]        rd_word =
      (araddr == REG_CTRL)   ? {31'h0, protect_q} :
      (araddr == REG_STATUS) ? rb.status :
      (araddr == REG_FLAGS)  ? {{(32 - NFLAGS){1'b0}}, flags_q} :
      (araddr == REG_ADDR)   ? rb.addr_view :
      (araddr == REG_DATA)   ? rb.data_view : 32'h0;

   assign rb.protect = protect_q;

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         awaddr_q <= '0; wdata_q <= '0; wstrb_q <= '0;
         aw_full_q <= 1'b0; w_full_q <= 1'b0; awready <= 1'b1; wready <= 1'b1;
         bvalid <= 1'b0; bresp <= RESP_OKAY; protect_q <= 1'b0; flags_q <= '0;
      end else begin
         if (aw_take) awaddr_q <= awaddr;
         if (w_take) begin
            wdata_q <= wdata;
            wstrb_q <= wstrb;
         end
         aw_full_q <= aw_full_d;
         w_full_q  <= w_full_d;
         awready   <= !aw_full_d;
         wready    <= !w_full_d;
         if (commit) begin
            bvalid <= 1'b1;
            bresp  <= mapped(awaddr_q) ? RESP_OKAY : RESP_DECERR;
         end else if (bvalid && bready) begin
            bvalid <= 1'b0;
         end
         if (lane0 && awaddr_q == REG_CTRL) protect_q <= wdata_q[CTRL_PROTECT_BIT];
         // A flag raised in the same cycle as its clear stays set.
         flags_q <= (flags_q & ~clr) | rb.flag_set;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         arready <= 1'b1; rvalid <= 1'b0; rdata <= '0; rresp <= RESP_OKAY;
      end else if (arvalid && arready) begin
         arready <= 1'b0;
         rvalid  <= 1'b1;
         rdata   <= rd_word;
         rresp   <= mapped(araddr) ? RESP_OKAY : RESP_DECERR;
      end else if (rvalid && rready) begin
         rvalid  <= 1'b0;
         arready <= 1'b1;
      end
   end
endmodule : earom_axil_regs

// ==== design/serial_earom_mode_sequencer.sv ====
/*
 Serial word memory with three-line mode control, one shared data pin and a
 register view over AXI4-Lite.
 Assumes the controller drives the mode lines, the slow timing clock and the
 data pin from outside this clock domain; all of them are synchronised here.
*/
// What this block does
// - Store one hundred fourteen-bit words; every access touches one whole word.
// - Address and data move serially over one shared two-way data pin.
// - Operating mode comes from the three-line code on the mode inputs.
// - Controller drives the pin on input modes; device drives it only shifting out.
// - Pin stays undriven during standby, read, erase and write.
// - Standby keeps address and data registers unchanged, output undriven.
// - Code 011 shifts the pin bit into the address register each pulse.
// - Code 100 copies the addressed word into the data register.
// - Code 101 drives the pin and shifts the data register out per pulse.
// - Code 010 clears every bit of the addressed word to zero.
// - Code 111 shifts pin bits into data register; address register unchanged.
// - Code 110 ORs the data register into the addressed word.
`timescale 1ns/1ps
module serial_earom_mode_sequencer
   import earom_pkg::*;
#(
   parameter int PROG_CYC  = PROGRAM_CYC,
   parameter int CLR_CYC   = CLEAR_CYC
) (
   input  wire logic              ref_clk,
   input  wire logic              rst_n,
   input  wire logic              timing_clk,
   input  wire logic              mode_select_line_a,
   input  wire logic              mode_select_line_b,
   input  wire logic              mode_select_line_c,
   input  wire logic              serial_data_in,
   output logic                   serial_data_out,
   output logic                   serial_data_oe,
   input  wire logic [AXI_AW-1:0] s_axil_awaddr,
   input  wire logic              s_axil_awvalid,
   output logic                   s_axil_awready,
   input  wire logic [31:0]       s_axil_wdata,
   input  wire logic [3:0]        s_axil_wstrb,
   input  wire logic              s_axil_wvalid,
   output logic                   s_axil_wready,
   output logic [1:0]             s_axil_bresp,
   output logic                   s_axil_bvalid,
   input  wire logic              s_axil_bready,
   input  wire logic [AXI_AW-1:0] s_axil_araddr,
   input  wire logic              s_axil_arvalid,
   output logic                   s_axil_arready,
   output logic [31:0]            s_axil_rdata,
   output logic [1:0]             s_axil_rresp,
   output logic                   s_axil_rvalid,
   input  wire logic              s_axil_rready
);
   if (PROG_CYC < 1 || PROG_CYC > (1 << CNT_W) ||
       CLR_CYC < 1 || CLR_CYC > (1 << CNT_W)) begin : g_bad_dwell
      $error("serial_earom_mode_sequencer: dwell count out of range");
   end

   reg_if rif ();

   logic [NSYNC-1:0]  sync1_q;
   logic [NSYNC-1:0]  sync2_q;
   logic              tclk_prev_q;
   logic [ADDR_W-1:0] addr_q, addr_d;
   logic [WORD_W-1:0] data_q, data_d;
   logic              data_out_q;
   logic              data_oe_q;
   op_state_t         op_q, op_d;
   mode_t             op_mode_q;
   logic [CNT_W-1:0]  cnt_q, cnt_d;
   logic [WORD_W-1:0] rd_data;
   logic              wr_en;
   logic [WORD_W-1:0] wr_data;
   logic [NFLAGS-1:0] flag_set;

   // The mode lines are synchronised one by one; a code change that straddles
   // a sample edge may show a passing code for one cycle, so erase and write
   // only commit after their full dwell and any blip there counts as an abort.
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         sync1_q     <= '0;
         sync2_q     <= '0;
         tclk_prev_q <= 1'b0;
      end else begin
         sync1_q     <= {timing_clk, mode_select_line_a, mode_select_line_b,
                         mode_select_line_c, serial_data_in};
         sync2_q     <= sync1_q;
         tclk_prev_q <= sync2_q[4];
      end
   end

   wire        pulse = sync2_q[4] && !tclk_prev_q;
   wire        din   = sync2_q[0];
   wire mode_t mode  = mode_t'(sync2_q[3:1]);

   wire [4:0]  tens  = onehot_idx(addr_q[ADDR_W-1:GRP_N]);
   wire [4:0]  units = onehot_idx(addr_q[GRP_N-1:0]);
   wire        addr_ok = tens[4] && units[4];
   wire [IDX_W-1:0] word_idx = IDX_W'({3'h0, tens[3:0]} * GRP_SCALE + {3'h0, units[3:0]});

   wire        dwell_mode = (mode == MD_ERASE) || (mode == MD_WRITE);
   wire [CNT_W-1:0] dwell_last =
      (op_mode_q == MD_ERASE) ? CNT_W'(CLR_CYC - 1) : CNT_W'(PROG_CYC - 1);

   earom_array #(
      .N_WORDS (WORDS),
      .W       (WORD_W)
   ) u_array (
      .ref_clk (ref_clk),
      .rd_idx  (word_idx),
      .rd_data (rd_data),
      .wr_en   (wr_en),
      .wr_idx  (word_idx),
      .wr_data (wr_data)
   );

   // Shift order: bits enter at bit 0 and leave from the top bit.
   always_comb begin
      addr_d = addr_q;
      data_d = data_q;
      case (mode)
         MD_ACC_ADDR: begin
            if (pulse) addr_d = {addr_q[ADDR_W-2:0], din};
         end
         MD_ACC_DATA: begin
            if (pulse) data_d = {data_q[WORD_W-2:0], din};
         end
         MD_READ: begin
            if (addr_ok) data_d = rd_data;
         end
         MD_SHIFT_OUT: begin
            if (pulse) data_d = {data_q[WORD_W-2:0], data_q[WORD_W-1]};
         end
         MD_STANDBY, MD_UNUSED: begin
            addr_d = addr_q;
         end
         default: begin
            data_d = data_q;
         end
      endcase
   end

   // Erase clears the word; write only adds set bits to what is stored, so an
   // unerased word keeps its stale ones.
   assign wr_data = (op_mode_q == MD_ERASE) ? '0 : (rd_data | data_q);

   always_comb begin
      op_d     = op_q;
      cnt_d    = cnt_q;
      wr_en    = 1'b0;
      flag_set = '0;
      case (op_q)
         OP_IDLE: begin
            cnt_d = '0;
            if (dwell_mode) begin
               if (!addr_ok || rif.protect) begin
                  flag_set[FLAG_REFUSED] = 1'b1;
                  op_d = OP_DONE;
               end else begin
                  op_d = OP_DWELL;
               end
            end
         end
         OP_DWELL: begin
            if (mode != op_mode_q) begin
               flag_set[FLAG_ABORT] = 1'b1;
               op_d = OP_IDLE;
            end else if (cnt_q == dwell_last) begin
               wr_en = 1'b1;
               flag_set[FLAG_DONE] = 1'b1;
               op_d = OP_DONE;
            end else begin
               cnt_d = cnt_q + CNT_W'(1);
            end
         end
         OP_DONE: begin
            if (mode != op_mode_q) op_d = OP_IDLE;
         end
         default: begin
            op_d = OP_IDLE;
         end
      endcase
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         op_q      <= OP_IDLE;
         op_mode_q <= MD_STANDBY;
         cnt_q     <= '0;
      end else begin
         op_q  <= op_d;
         cnt_q <= cnt_d;
         if (op_q == OP_IDLE) op_mode_q <= mode;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         addr_q     <= '0;
         data_q     <= '0;
         data_out_q <= 1'b0;
         data_oe_q  <= 1'b0;
      end else begin
         addr_q     <= addr_d;
         data_q     <= data_d;
         data_out_q <= data_d[WORD_W-1];
         data_oe_q  <= (mode == MD_SHIFT_OUT);
      end
   end

   assign serial_data_out = data_out_q;
   assign serial_data_oe  = data_oe_q;

   assign rif.flag_set  = flag_set;
   assign rif.status    = {24'h0, data_oe_q, op_q, addr_ok, 1'b0, mode};
   assign rif.addr_view = {{(32 - ADDR_W){1'b0}}, addr_q};
   assign rif.data_view = {{(32 - WORD_W){1'b0}}, data_q};

   earom_axil_regs u_regs (
      .ref_clk (ref_clk),
      .rst_n   (rst_n),
      .awaddr  (s_axil_awaddr),
      .awvalid (s_axil_awvalid),
      .awready (s_axil_awready),
      .wdata   (s_axil_wdata),
      .wstrb   (s_axil_wstrb),
      .wvalid  (s_axil_wvalid),
      .wready  (s_axil_wready),
      .bresp   (s_axil_bresp),
      .bvalid  (s_axil_bvalid),
      .bready  (s_axil_bready),
      .araddr  (s_axil_araddr),
      .arvalid (s_axil_arvalid),
      .arready (s_axil_arready),
      .rdata   (s_axil_rdata),
      .rresp   (s_axil_rresp),
      .rvalid  (s_axil_rvalid),
      .rready  (s_axil_rready),
      .rb      (rif.regs)
   );

   sequence s_idle_regs;
      addr_q == $past(addr_q) && data_q == $past(data_q);
   endsequence

   sequence s_dwell_broken;
      op_q == OP_DWELL && mode != op_mode_q;
   endsequence

   sequence s_back_idle;
      op_q == OP_IDLE;
   endsequence

   property p_standby_hold;
      @(posedge ref_clk) disable iff (!rst_n)
         mode == MD_STANDBY |=> s_idle_regs ##0 !data_oe_q;
   endproperty

   property p_unused_hold;
      @(posedge ref_clk) disable iff (!rst_n)
         mode == MD_UNUSED |=> s_idle_regs ##0 !data_oe_q;
   endproperty

   property p_abort;
      @(posedge ref_clk) disable iff (!rst_n)
         s_dwell_broken |-> flag_set[FLAG_ABORT] && !wr_en ##1 s_back_idle;
   endproperty

   AST_STANDBY_HOLD: assert property (p_standby_hold)
      else $error("registers changed or pin driven in standby");

   AST_UNUSED_HOLD: assert property (p_unused_hold)
      else $error("unused code did not behave like standby");

   AST_ADDR_SHIFT: assert property (@(posedge ref_clk) disable iff (!rst_n)
      mode == MD_ACC_ADDR && pulse |=>
         addr_q == {$past(addr_q[ADDR_W-2:0]), $past(din)} && data_q == $past(data_q))
      else $error("address shift wrong");

   AST_DATA_SHIFT: assert property (@(posedge ref_clk) disable iff (!rst_n)
      mode == MD_ACC_DATA && pulse |=>
         data_q == {$past(data_q[WORD_W-2:0]), $past(din)} && addr_q == $past(addr_q))
      else $error("data shift wrong or address moved");

   AST_READ_LOAD: assert property (@(posedge ref_clk) disable iff (!rst_n)
      mode == MD_READ && addr_ok |=> data_q == $past(rd_data))
      else $error("read did not load the addressed word");

   AST_OUT_BIT: assert property (@(posedge ref_clk) disable iff (!rst_n)
      mode == MD_SHIFT_OUT && pulse |=> data_out_q == $past(data_q[WORD_W-2]) && data_oe_q)
      else $error("shift out did not present the next bit");

   AST_PIN_FLOAT: assert property (@(posedge ref_clk) disable iff (!rst_n)
      mode != MD_SHIFT_OUT |=> !data_oe_q)
      else $error("pin driven outside shift out");

   AST_ERASE_ZERO: assert property (@(posedge ref_clk) disable iff (!rst_n)
      wr_en && op_mode_q == MD_ERASE |-> wr_data == '0 && mode == MD_ERASE)
      else $error("erase did not clear the word");

   AST_WRITE_MERGE: assert property (@(posedge ref_clk) disable iff (!rst_n)
      wr_en && op_mode_q == MD_WRITE |-> wr_data == (rd_data | data_q) && addr_ok)
      else $error("write stored wrong word");

   AST_DWELL_FULL: assert property (@(posedge ref_clk) disable iff (!rst_n)
      wr_en |-> cnt_q == dwell_last && op_q == OP_DWELL ##1 op_q == OP_DONE)
      else $error("commit before full dwell");

   AST_ABORT: assert property (p_abort)
      else $error("broken dwell did not abort");

   // Independent count of cycles in the current dwell, so that the commit check
   // does not lean on the sequencer's own counter and its end value.
   logic [CNT_W-1:0] held_q;

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         held_q <= '0;
      end else if (op_q == OP_DWELL) begin
         held_q <= held_q + CNT_W'(1);
      end else begin
         held_q <= '0;
      end
   end

   AST_DWELL_COUNT: assert property (@(posedge ref_clk) disable iff (!rst_n)
      wr_en |-> 32'(held_q) == ((op_mode_q == MD_ERASE) ? CLR_CYC : PROG_CYC) - 1)
      else $error("commit after wrong number of dwell cycles");

   AST_NO_STRAY_WRITE: assert property (@(posedge ref_clk) disable iff (!rst_n)
      op_q != OP_DWELL |-> !wr_en)
      else $error("array written outside a dwell");

   AST_ADDR_HOLD: assert property (@(posedge ref_clk) disable iff (!rst_n)
      mode != MD_ACC_ADDR |=> addr_q == $past(addr_q))
      else $error("address register moved outside address entry");

   AST_REFUSE: assert property (@(posedge ref_clk) disable iff (!rst_n)
      op_q == OP_IDLE && dwell_mode && (!addr_ok || rif.protect) |->
         flag_set[FLAG_REFUSED] && !wr_en ##1 op_q == OP_DONE)
      else $error("erase or write with bad address or protect not refused");

   AST_DATA_HOLD: assert property (@(posedge ref_clk) disable iff (!rst_n)
      dwell_mode |=> data_q == $past(data_q) && addr_q == $past(addr_q))
      else $error("registers moved during erase or write");
endmodule : serial_earom_mode_sequencer

// ==== tb/ctrl_model.sv ====
/*
 External controller model: mode lines, slow timing clock and data pin.
 Assumes calls from one bench process, paced by ref_clk.
*/
`timescale 1ns/1ps
module ctrl_model (
   input  wire logic  ref_clk,
   input  wire logic  sdo,
   input  wire logic  oe,
   output logic       timing_clk,
   output logic [2:0] mode,
   output wire logic  pin
);
   logic drv = 1'h0;
   logic dq  = 1'h0;
   logic lq  = 1'h0;
   // No pull on the pin, so a released pin toggles instead of keeping its last bit.
   assign pin = oe ? sdo : (drv ? dq : lq);
   always @(posedge ref_clk) lq <= ~lq;
   initial timing_clk = 1'h0;
   initial mode = 3'h0;
   task automatic set_mode(input logic [2:0] m);
      drv  <= (m == 3'h3) || (m == 3'h7);
      mode <= m;
      repeat (6) @(posedge ref_clk);
   endtask : set_mode
   // Pulses run far faster than the real timing clock so that runs stay short.
   task automatic pulse(input logic b, output logic seen);
      dq <= b;
      repeat (4) @(posedge ref_clk);
      seen = pin;
      timing_clk <= 1'h1;
      repeat (6) @(posedge ref_clk);
      timing_clk <= 1'h0;
      repeat (6) @(posedge ref_clk);
   endtask : pulse
endmodule : ctrl_model

// ==== tb/serial_earom_mode_sequencer_bench.sv ====
/*
 Self-checking bench for the serial word memory sequencer, with an integer model.
 Assumes ctrl_model on the serial side and the package earom_pkg.
*/
`timescale 1ns/1ps
module serial_earom_mode_sequencer_bench
   import earom_pkg::*;
();
   localparam int DWELL = 20;
   logic              ref_clk = 1'h0;
   logic              rst_n = 1'h0;
   logic [AXI_AW-1:0] awaddr = 8'h0, araddr = 8'h0;
   logic [31:0]       wdata = 32'h0, rdata, a, dv;
   logic [3:0]        wstrb = 4'hF;
   logic              awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0;
   logic              rready = 1'h0, awready, wready, bvalid, arready, rvalid;
   logic              oe, sdo, tclk, pin, s;
   logic [1:0]        bresp, rresp;
   logic [2:0]        mode;
   logic [2:0]        idle [2] = '{3'h0, 3'h1};
   int                n_mismatch = 0, n_checks = 0, seed = 97117, w;
   int                mem [WORDS];
   always #5 ref_clk = ~ref_clk;
   serial_earom_mode_sequencer #(.PROG_CYC(DWELL), .CLR_CYC(DWELL)) uut (
      .ref_clk(ref_clk), .rst_n(rst_n), .timing_clk(tclk), .serial_data_in(pin),
      .mode_select_line_a(mode[2]), .mode_select_line_b(mode[1]),
      .mode_select_line_c(mode[0]), .serial_data_out(sdo), .serial_data_oe(oe),
      .s_axil_awaddr(awaddr), .s_axil_awvalid(awvalid), .s_axil_awready(awready),
      .s_axil_wdata(wdata), .s_axil_wstrb(wstrb), .s_axil_wvalid(wvalid),
      .s_axil_wready(wready), .s_axil_bresp(bresp), .s_axil_bvalid(bvalid),
      .s_axil_bready(bready), .s_axil_araddr(araddr), .s_axil_arvalid(arvalid),
      .s_axil_arready(arready), .s_axil_rdata(rdata), .s_axil_rresp(rresp),
      .s_axil_rvalid(rvalid), .s_axil_rready(rready));
   ctrl_model cm (.ref_clk(ref_clk), .sdo(sdo), .oe(oe), .timing_clk(tclk), .mode(mode),
                  .pin(pin));
   task automatic chk(input string nm, input logic [31:0] sn, input logic [31:0] ex);
      n_checks++;
      if (sn !== ex) begin
         n_mismatch++;
         $display("[FAIL] %s expected %0h seen %0h", nm, ex, sn);
      end
   endtask : chk
   task automatic summarize();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : summarize
   task automatic tmo(input int t);
      if (t >= 99) n_mismatch++;
      if (t >= 99) summarize();
   endtask : tmo
   // Address and data go out together; each is let go once it has been taken.
   task automatic wr(input logic [7:0] ad, input logic [31:0] dt);
      int t;
      @(posedge ref_clk);
      awaddr <= ad;
      wdata <= dt;
      {awvalid, wvalid, bready} <= 3'h7;
      for (t = 0; t < 99; t++) begin
         @(posedge ref_clk);
         if (awready) awvalid <= 1'h0;
         if (wready) wvalid <= 1'h0;
         if (bvalid) break;
      end
      bready <= 1'h0;
      chk("bresp", {30'h0, bresp}, {30'h0, (ad > 8'h10) ? RESP_DECERR : RESP_OKAY});
      tmo(t);
   endtask : wr
   task automatic rd(input logic [7:0] ad, input logic [31:0] ex, input string nm);
      int t;
      @(posedge ref_clk);
      araddr <= ad;
      {arvalid, rready} <= 2'h3;
      for (t = 0; t < 99; t++) begin
         @(posedge ref_clk);
         if (arready) arvalid <= 1'h0;
         if (rvalid) break;
      end
      rready <= 1'h0;
      chk(nm, rdata, ex);
      chk("rresp", {30'h0, rresp}, {30'h0, (ad > 8'h10) ? RESP_DECERR : RESP_OKAY});
      tmo(t);
   endtask : rd
   task automatic go(input logic [2:0] m);
      cm.set_mode(m);
      chk("drive_enable", {31'h0, oe}, {31'h0, m == 3'h5});
   endtask : go
   task automatic send(input logic [31:0] v, input int n);
      for (int i = n - 1; i >= 0; i--) cm.pulse(v[i], s);
   endtask : send
   initial begin
      repeat (4) @(posedge ref_clk);
      rst_n <= 1'h1;
      chk("oe_reset", {31'h0, oe}, 32'h0);
      wr(8'h40, 32'h1);
      rd(8'h40, 32'h0, "unmapped");
      for (int k = 0; k < 3; k++) begin
         w = {$random(seed)} % WORDS;
         a = (32'h1 << (10 + w / 10)) | (32'h1 << (w % 10));
         dv = $random(seed) & 32'h3FFF;
         go(3'h3);
         send(a, 20);
         rd(REG_ADDR, a, "addr_reg");
         go(3'h2);
         repeat (2 * DWELL) @(posedge ref_clk);
         mem[w] = 0;
         rd(REG_FLAGS, 32'h1 << FLAG_DONE, "done_flag");
         wr(REG_FLAGS, 32'h7);
         go(3'h7);
         send(dv, 14);
         rd(REG_DATA, dv, "data_reg");
         go(3'h6);
         repeat (2 * DWELL) @(posedge ref_clk);
         mem[w] = mem[w] | dv;
         foreach (idle[j]) begin
            go(idle[j]);
            send(~dv, 14);
            rd(REG_DATA, dv, "data_kept");
            rd(REG_ADDR, a, "addr_kept");
         end
         go(3'h7);
         send(~dv, 14);
         go(3'h4);
         rd(REG_DATA, mem[w], "read_word");
         go(3'h5);
         rd(REG_STATUS, 32'h95, "status");
         for (int i = 13; i >= 0; i--) begin
            cm.pulse(1'h0, s);
            chk("bit_out", {31'h0, s}, {31'h0, mem[w][i]});
         end
      end
      wr(REG_FLAGS, 32'h7);
      go(3'h2);
      go(3'h0);
      rd(REG_FLAGS, 32'h1 << FLAG_ABORT, "abort_flag");
      wr(REG_CTRL, 32'h1);
      wr(REG_FLAGS, 32'h7);
      go(3'h2);
      repeat (2 * DWELL) @(posedge ref_clk);
      rd(REG_FLAGS, 32'h1 << FLAG_REFUSED, "refused_flag");
      wr(REG_CTRL, 32'h0);
      go(3'h4);
      rd(REG_DATA, mem[w], "word_kept");
      summarize();
   end
endmodule : serial_earom_mode_sequencer_bench
